// ===== hdl/sswg_top.sv
// Overview of operation
// - Monitor B output is high while its input is above threshold three, low below it.
// - Monitor B output follows its comparator one clock late, through a single flop, with no added hold timing.
// - Monitor A output follows threshold two with no power-up reset delay.
// - The supply reset output is active high whenever the supply is below threshold one.
// - At power-up the supply reset output is high and stays high for the hold time.
// - A high manual reset input starts a reset cycle on the supply reset output.
// - After manual reset falls the supply reset output stays high for the full hold time.
// - The hold time is chosen by the two delay select bits of the control register.
// - While write protect is high every nonvolatile write is blocked.
// - While write protect is high and the wiper lock bit is one, all wiper writes are refused.
// - An undriven write protect input counts as low, so protection is off.
// - The serial data input is sampled every cycle and never gated off.
// - Both monitor output states are held in status bits readable by the host.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "sswg_cfg.svh"

module sswg_top #(
  parameter int unsigned HOLD0_CYC = `SSWG_HOLD0_US * `SSWG_CLK_MHZ,
  parameter int unsigned HOLD1_CYC = `SSWG_HOLD1_US * `SSWG_CLK_MHZ,
  parameter int unsigned HOLD2_CYC = `SSWG_HOLD2_US * `SSWG_CLK_MHZ,
  parameter int unsigned HOLD3_CYC = `SSWG_HOLD3_US * `SSWG_CLK_MHZ
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire sswg_pkg::sswg_addr_t paddr,
  input wire sswg_pkg::sswg_word_t pwdata,
  output logic pready,
  output sswg_pkg::sswg_word_t prdata,
  output logic pslverr,
  // comparator flags
  input wire logic supply_above_threshold,
  input wire logic aux_monitor_a_input,
  input wire logic aux_monitor_b_input,
  // manual reset and write protect pins
  input wire logic manual_reset_in,
  input wire logic write_protect_in,
  // serial data input sample
  input wire logic sda_in,
  // write requests from the serial engine
  input wire logic wr_req,
  input wire logic wr_nonvolatile,
  input wire logic wr_to_wiper,
  output logic wr_grant,
  output logic wr_reject,
  // open-drain outputs, oe high while the pin is pulled low
  output logic supply_reset_out,
  output logic supply_reset_oe,
  output logic aux_monitor_a_out,
  output logic aux_monitor_a_oe,
  output logic aux_monitor_b_out,
  output logic aux_monitor_b_oe,
  // interrupt
  output logic irq
);
  import sswg_pkg::*;

  // =====================================================
  // state
  sswg_state_s s;
  sswg_state_s next_s;
  // every flop sits in one struct behind one reset branch

  logic undervolt;
  logic rst_src;
  logic [31:0] hold_cyc;
  logic hold_done;
  logic [31:0] hold_dec;

  logic nv_block;
  logic wiper_block;
  logic blocked;

  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic wr_ctrl;
  logic wr_imask;
  logic rd_istat;
  logic hit;

  logic [1:0] mon_in;
  logic [1:0] mon_q;
  logic [1:0] mon_chg;
  logic [3:0] ev;
  sswg_word_t rdata;

  // =====================================================
  // hold time lookup
  always_comb begin
    unique case (s.dly_sel)
      2'b00: hold_cyc = HOLD0_CYC;
      2'b01: hold_cyc = HOLD1_CYC;
      2'b10: hold_cyc = HOLD2_CYC;
      2'b11: hold_cyc = HOLD3_CYC;
    endcase
  end

  // =====================================================
  // hold counter
  // the select is read only on a reload, so a change never cuts a running hold short
  assign hold_done = (s.cnt <= 32'h0000_0001);
  assign hold_dec = s.cnt - 32'h0000_0001;

  // =====================================================
  // reset sources and write guard
  // power-up enters through srst, which forces the active state
  assign undervolt = ~supply_above_threshold;
  assign rst_src = undervolt | manual_reset_in;

  // only a driven high level protects; the pad pull-down maps a floating pin to low
  assign nv_block = write_protect_in & wr_nonvolatile;
  assign wiper_block = write_protect_in & s.wlock & wr_to_wiper;
  assign blocked = nv_block | wiper_block;

  // =====================================================
  // apb decode
  // reads are answered from the first access cycle; a write lands on the edge
  // that samples pready high, the only edge at which the access is complete
  assign acc = psel & penable & ~s.pready;
  assign wr_acc = psel & penable & s.pready & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign wr_ctrl = wr_acc & (paddr == `SSWG_OFS_CTRL);
  assign wr_imask = wr_acc & (paddr == `SSWG_OFS_IMASK);
  assign rd_istat = rd_acc & (paddr == `SSWG_OFS_ISTAT);

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    unique case (paddr)
      `SSWG_OFS_CTRL: begin
        rdata[`SSWG_CTRL_SEL_LO] = s.dly_sel[0];
        rdata[`SSWG_CTRL_SEL_HI] = s.dly_sel[1];
        rdata[`SSWG_CTRL_WLOCK] = s.wlock;
      end
      `SSWG_OFS_STAT: begin
        rdata[`SSWG_STAT_MON_A] = s.mon_a;
        rdata[`SSWG_STAT_MON_B] = s.mon_b;
        rdata[`SSWG_STAT_SUP_RST] = s.sup_rst;
        rdata[`SSWG_STAT_WP] = s.wp;
        rdata[`SSWG_STAT_SDA] = s.sda_smp;
      end
      `SSWG_OFS_ISTAT: begin
        rdata[3:0] = s.irq_st;
      end
      `SSWG_OFS_IMASK: begin
        rdata[3:0] = s.irq_mask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // =====================================================
  // monitor channels
  // both comparators take the same path; a change on either raises its own event bit
  assign mon_in = {aux_monitor_b_input, aux_monitor_a_input};
  assign mon_q = {s.mon_b, s.mon_a};
  for (genvar ch = 0; ch < 2; ch++) begin : g_mon
    assign mon_chg[ch] = mon_in[ch] ^ mon_q[ch];
  end

  // =====================================================
  // next state
  always_comb begin
    next_s = s;

    // monitors are plain copies; the single flop only keeps outputs glitch free
    next_s.mon_a = aux_monitor_a_input;
    next_s.mon_a_oe = ~aux_monitor_a_input;
    next_s.mon_b = aux_monitor_b_input;
    next_s.mon_b_oe = ~aux_monitor_b_input;
    next_s.wp = write_protect_in;
    next_s.sda_smp = sda_in;

    // supply reset sequencer
    if (rst_src) begin
      next_s.rst_st = SSWG_RST_ACTIVE;
      next_s.cnt = hold_cyc;
      next_s.sup_rst = 1'b1;
    end else begin
      unique case (s.rst_st)
        SSWG_RST_ACTIVE: begin
          next_s.rst_st = SSWG_RST_HOLD;
          next_s.cnt = hold_cyc;
          next_s.sup_rst = 1'b1;
        end
        SSWG_RST_HOLD: begin
          if (hold_done) begin
            next_s.rst_st = SSWG_RST_IDLE;
            next_s.sup_rst = 1'b0;
          end else begin
            next_s.cnt = hold_dec;
          end
        end
        SSWG_RST_IDLE: begin
          next_s.sup_rst = 1'b0;
        end
        default: begin
          // an unused code falls back into an active reset instead of releasing
          next_s.rst_st = SSWG_RST_ACTIVE;
          next_s.sup_rst = 1'b1;
        end
      endcase
    end
    next_s.sup_rst_oe = ~next_s.sup_rst;

    // write guard answers, one cycle pulses
    next_s.wr_grant = wr_req & ~blocked;
    next_s.wr_reject = wr_req & blocked;

    // events
    ev = 4'h0;
    ev[`SSWG_EV_RST] = next_s.sup_rst & ~s.sup_rst;
    ev[`SSWG_EV_MON_A] = mon_chg[0];
    ev[`SSWG_EV_MON_B] = mon_chg[1];
    ev[`SSWG_EV_WREJ] = next_s.wr_reject;

    // apb access: one wait state, pready pulses for one cycle
    next_s.pready = acc;
    next_s.pslverr = acc & ~hit;
    if (rd_acc && hit) begin
      next_s.prdata = rdata;
    end else begin
      next_s.prdata = 32'h0000_0000;
    end

    if (wr_ctrl) begin
      next_s.dly_sel[0] = pwdata[`SSWG_CTRL_SEL_LO];
      next_s.dly_sel[1] = pwdata[`SSWG_CTRL_SEL_HI];
      next_s.wlock = pwdata[`SSWG_CTRL_WLOCK];
    end
    if (wr_imask) begin
      next_s.irq_mask = pwdata[3:0];
    end

    // read clears, but a new event in the same cycle survives
    if (rd_istat) begin
      next_s.irq_st = ev;
    end else begin
      next_s.irq_st = s.irq_st | ev;
    end
    // level output: stays high until software clears the status or masks it
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);
  end

  // =====================================================
  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      s.dly_sel <= `SSWG_CTRL_RST;
      s.wlock <= 1'b0;
      s.rst_st <= SSWG_RST_ACTIVE;
      s.cnt <= HOLD0_CYC;
      s.sup_rst <= 1'b1;
      s.sup_rst_oe <= 1'b0;
      s.mon_a <= 1'b0;
      s.mon_a_oe <= 1'b1;
      s.mon_b <= 1'b0;
      s.mon_b_oe <= 1'b1;
      s.wp <= 1'b0;
      s.sda_smp <= 1'b1;
      s.irq_st <= 4'h0;
      s.irq_mask <= `SSWG_IMASK_RST;
      s.irq <= 1'b0;
      s.pready <= 1'b0;
      s.pslverr <= 1'b0;
      s.prdata <= 32'h0000_0000;
      s.wr_grant <= 1'b0;
      s.wr_reject <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // =====================================================
  // outputs
  // every pin is a flop of the state struct, so no input reaches a pin combinationally
  // apb
  assign pready = s.pready;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;

  // write guard
  assign wr_grant = s.wr_grant;
  assign wr_reject = s.wr_reject;

  // open-drain pins
  assign supply_reset_out = s.sup_rst;
  assign supply_reset_oe = s.sup_rst_oe;
  assign aux_monitor_a_out = s.mon_a;
  assign aux_monitor_a_oe = s.mon_a_oe;
  assign aux_monitor_b_out = s.mon_b;
  assign aux_monitor_b_oe = s.mon_b_oe;

  // interrupt
  assign irq = s.irq;

endmodule : sswg_top

// ===== hdl/sswg_cfg.svh
`ifndef SSWG_CFG_SVH
`define SSWG_CFG_SVH

// =====================================================
// clock
`define SSWG_CLK_MHZ 200

// =====================================================
// reset hold times selectable by the delay select bits, in microseconds
`define SSWG_HOLD0_US 1000
`define SSWG_HOLD1_US 2000
`define SSWG_HOLD2_US 4000
`define SSWG_HOLD3_US 8000

// =====================================================
// register byte offsets
`define SSWG_OFS_CTRL 8'h00
`define SSWG_OFS_STAT 8'h04
`define SSWG_OFS_ISTAT 8'h08
`define SSWG_OFS_IMASK 8'h0c

// =====================================================
// control register fields
`define SSWG_CTRL_SEL_LO 0
`define SSWG_CTRL_SEL_HI 1
`define SSWG_CTRL_WLOCK 2
`define SSWG_CTRL_RST 2'h0

// =====================================================
// status register fields
`define SSWG_STAT_MON_A 0
`define SSWG_STAT_MON_B 1
`define SSWG_STAT_SUP_RST 2
`define SSWG_STAT_WP 3
`define SSWG_STAT_SDA 4

// =====================================================
// interrupt status and mask fields
`define SSWG_EV_RST 0
`define SSWG_EV_MON_A 1
`define SSWG_EV_MON_B 2
`define SSWG_EV_WREJ 3
`define SSWG_EV_N 4
`define SSWG_IMASK_RST 4'h0

`endif

// ===== hdl/sswg_pkg.sv
package sswg_pkg;

  // =====================================================
  // types
  typedef logic [31:0] sswg_word_t;
  typedef logic [7:0] sswg_addr_t;

  typedef enum logic [1:0] {
    SSWG_RST_ACTIVE,
    SSWG_RST_HOLD,
    SSWG_RST_IDLE
  } sswg_rst_e;

  typedef struct packed {
    logic [1:0] dly_sel;
    logic wlock;
    sswg_rst_e rst_st;
    logic [31:0] cnt;
    logic sup_rst;
    logic sup_rst_oe;
    logic mon_a;
    logic mon_a_oe;
    logic mon_b;
    logic mon_b_oe;
    logic wp;
    logic sda_smp;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic wr_grant;
    logic wr_reject;
  } sswg_state_s;

endpackage : sswg_pkg

// ===== verif/sswg_checker.sv
`timescale 1ns/1ps
module sswg_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // watched pins
  input wire logic supply_above_threshold,
  input wire logic aux_monitor_a_input,
  input wire logic aux_monitor_b_input,
  input wire logic manual_reset_in,
  input wire logic write_protect_in,
  input wire logic wr_req,
  input wire logic wr_nonvolatile,
  input wire logic wr_grant,
  input wire logic wr_reject,
  input wire logic supply_reset_out,
  input wire logic supply_reset_oe,
  input wire logic aux_monitor_a_out,
  input wire logic aux_monitor_a_oe,
  input wire logic aux_monitor_b_out,
  input wire logic aux_monitor_b_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ====
  // monitors, one flop late
  property p_mon_b_hi; aux_monitor_b_input |=> aux_monitor_b_out; endproperty
  a_mon_b_hi: assert property (p_mon_b_hi) else $error("mon b high");
  property p_mon_b_lo; !aux_monitor_b_input |=> !aux_monitor_b_out; endproperty
  a_mon_b_lo: assert property (p_mon_b_lo) else $error("mon b low");
  property p_mon_a_hi; aux_monitor_a_input |=> aux_monitor_a_out; endproperty
  a_mon_a_hi: assert property (p_mon_a_hi) else $error("mon a high");
  property p_mon_a_lo; !aux_monitor_a_input |=> !aux_monitor_a_out; endproperty
  a_mon_a_lo: assert property (p_mon_a_lo) else $error("mon a low");
  property p_mon_a_oe; aux_monitor_a_oe == !aux_monitor_a_out; endproperty
  a_mon_a_oe: assert property (p_mon_a_oe) else $error("mon a oe polarity");
  property p_mon_b_oe; aux_monitor_b_oe == !aux_monitor_b_out; endproperty
  a_mon_b_oe: assert property (p_mon_b_oe) else $error("mon b oe polarity");
  // ====
  // supply reset
  property p_sup; !supply_above_threshold |=> supply_reset_out; endproperty
  a_sup: assert property (p_sup) else $error("supply reset");
  property p_por; $fell(srst) |-> supply_reset_out [*8]; endproperty
  a_por: assert property (p_por) else $error("power-up hold");
  property p_mr; manual_reset_in |=> supply_reset_out; endproperty
  a_mr: assert property (p_mr) else $error("manual reset");
  property p_mr_hold; $fell(manual_reset_in) |-> supply_reset_out [*8]; endproperty
  a_mr_hold: assert property (p_mr_hold) else $error("manual hold");
  property p_rel;
    $fell(supply_reset_out) |-> !$past(manual_reset_in) && $past(supply_above_threshold);
  endproperty
  a_rel: assert property (p_rel) else $error("release with source");
  property p_oe; supply_reset_oe == !supply_reset_out; endproperty
  a_oe: assert property (p_oe) else $error("oe polarity");
  // ====
  // write guard
  property p_wp; wr_req && write_protect_in && wr_nonvolatile |=> wr_reject; endproperty
  a_wp: assert property (p_wp) else $error("nv write passed");
  property p_free; wr_req && !write_protect_in |=> wr_grant && !wr_reject; endproperty
  a_free: assert property (p_free) else $error("write refused");
endmodule : sswg_checker

bind sswg_top sswg_checker chk_u (.*);

// ===== verif/sswg_partner.sv
`timescale 1ns/1ps
module sswg_partner (
  // requests from the bench
  input wire logic mr_req,
  input wire logic wp_drv,
  input wire logic wp_en,
  // pins
  input wire logic supply_reset_oe,
  output logic manual_reset_in,
  output logic write_protect_in,
  output logic reset_line
);
  // manual reset follows the bench request directly, low while it is idle
  assign manual_reset_in = mr_req;
  // undriven write protect falls to low
  assign write_protect_in = wp_en ? wp_drv : 1'b0;
  // pulled-up open drain, low while the device pulls it
  assign reset_line = supply_reset_oe ? 1'b0 : 1'b1;
endmodule : sswg_partner

// ===== verif/sswg_top_tb.sv
`timescale 1ns/1ps
`include "sswg_cfg.svh"
module sswg_top_tb;
  import sswg_pkg::*;
  // ====
  // signals
  localparam int H[4] = '{8, 12, 16, 20};
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, irq, sda_in;
  logic supply_above_threshold, aux_monitor_a_input, aux_monitor_b_input;
  logic manual_reset_in, write_protect_in, mr_req, wp_drv, wp_en, reset_line;
  logic wr_req, wr_nonvolatile, wr_to_wiper, wr_grant, wr_reject;
  logic supply_reset_out, supply_reset_oe, aux_monitor_a_out, aux_monitor_a_oe;
  logic aux_monitor_b_out, aux_monitor_b_oe, err;
  sswg_addr_t paddr;
  sswg_word_t pwdata, prdata, rd;
  int n_fail, checks, n;
  sswg_top #(.HOLD0_CYC(H[0]), .HOLD1_CYC(H[1]), .HOLD2_CYC(H[2]), .HOLD3_CYC(H[3])) dut_u (.*);
  sswg_partner part_u (.*);
  // ====
  // tasks
  task automatic chk(input string nm, input sswg_word_t e, input sswg_word_t g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input sswg_addr_t a, input sswg_word_t d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge mclk);
    end
    chk("pready", 1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wreq(input logic nv, input logic wip, input logic rej);
    @(posedge mclk);
    wr_req <= 1'b1;
    wr_nonvolatile <= nv;
    wr_to_wiper <= wip;
    @(posedge mclk);
    wr_req <= 1'b0;
    @(posedge mclk);
    chk("wr_reject", rej, wr_reject);
    chk("wr_grant", !rej, wr_grant);
  endtask : wreq
  // the count runs from the edge that first sees manual reset low
  task automatic mr_hold(input int e);
    @(posedge mclk);
    mr_req <= 1'b1;
    repeat (3) @(posedge mclk);
    mr_req <= 1'b0;
    n = 0;
    @(posedge mclk);
    while (reset_line === 1'b1 && n < 100) begin
      n++;
      @(posedge mclk);
    end
    chk("hold", e, n);
  endtask : mr_hold
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  // ====
  // clock, watchdog, tests
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, mr_req, wp_en, wr_req} = '0;
    {wr_nonvolatile, wr_to_wiper, aux_monitor_a_input, aux_monitor_b_input} = '0;
    {srst, supply_above_threshold, sda_in, wp_drv} = '1;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    chk("rst_out", 1, supply_reset_out);
    apb(0, `SSWG_OFS_CTRL, 0);
    chk("ctrl", 0, rd);
    apb(0, `SSWG_OFS_IMASK, 0);
    chk("imask", 0, rd);
    repeat (30) @(posedge mclk);
    chk("rst_out", 0, supply_reset_out);
    $display("test power-up done");
    for (int s = 0; s < 4; s++) begin
      apb(1, `SSWG_OFS_CTRL, s);
      apb(0, `SSWG_OFS_CTRL, 0);
      chk("ctrl", s, rd);
      mr_hold(H[s] + 1);
    end
    supply_above_threshold <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("rst_out", 1, supply_reset_out);
    supply_above_threshold <= 1'b1;
    repeat (30) @(posedge mclk);
    chk("rst_out", 0, supply_reset_out);
    $display("test reset sources done");
    for (int i = 0; i < 16; i++) begin
      apb(1, `SSWG_OFS_CTRL, {29'h0, i[1], 2'b00});
      wp_en <= i[0];
      wreq(i[2], i[3], i[0] & (i[2] | i[1] & i[3]));
    end
    $display("test write guard done");
    wp_en <= 1'b0;
    apb(0, `SSWG_OFS_ISTAT, 0);
    apb(1, `SSWG_OFS_IMASK, 2);
    apb(0, `SSWG_OFS_IMASK, 0);
    chk("imask", 2, rd);
    aux_monitor_a_input <= 1'b1;
    aux_monitor_b_input <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("irq", 1, irq);
    chk("mon_a", 1, aux_monitor_a_out);
    chk("mon_a_oe", 0, aux_monitor_a_oe);
    chk("mon_b_oe", 0, aux_monitor_b_oe);
    apb(0, `SSWG_OFS_STAT, 0);
    chk("stat", 32'h13, rd);
    chk("pslverr", 0, err);
    apb(0, `SSWG_OFS_ISTAT, 0);
    chk("istat", 6, rd);
    aux_monitor_b_input <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("irq", 0, irq);
    chk("mon_b", 0, aux_monitor_b_out);
    chk("mon_b_oe", 1, aux_monitor_b_oe);
    sda_in <= 1'b0;
    apb(0, `SSWG_OFS_STAT, 0);
    chk("stat", 32'h01, rd);
    apb(0, 8'h10, 0);
    chk("pslverr", 1, err);
    $display("test status done");
    close_out();
  end
endmodule : sswg_top_tb
